/* logic/cpf_regs.vh */
`ifndef CPF_REGS_VH
`define CPF_REGS_VH

// Special and user register numbers
`define CPF_SR_CP_ENABLE     8'he0
`define CPF_UR_FP_CONTROL    8'he8
`define CPF_UR_FP_STATUS     8'he9

// Special register access kinds
`define CPF_SR_OP_READ       2'h0
`define CPF_SR_OP_WRITE      2'h1
`define CPF_SR_OP_EXCHANGE   2'h2

// Intermediate opcodes for coprocessor load/store
`define CPF_OP_LDST_IMM      4'h3
`define CPF_OP_LDST_INDEXED  4'h4

// Control word fields
`define CPF_FC_RND_MSB       1
`define CPF_FC_RND_LSB       0
`define CPF_FC_ENA_MSB       6
`define CPF_FC_ENA_LSB       2
`define CPF_FC_RSV_MSB       31
`define CPF_FC_RSV_LSB       12
`define CPF_FC_WR_MASK       32'hffff_f07f

// Status word fields
`define CPF_FS_FLG_MSB       11
`define CPF_FS_FLG_LSB       7
`define CPF_FS_RSV_MSB       31
`define CPF_FS_RSV_LSB       12
`define CPF_FS_WR_MASK       32'hffff_ff80

// Rounding encodings
`define CPF_RND_NEAREST      2'h0
`define CPF_RND_ZERO         2'h1
`define CPF_RND_PLUS_INF     2'h2
`define CPF_RND_MINUS_INF    2'h3

// Reset values of visible state
`define CPF_ZERO32           32'h0000_0000
`define CPF_ZERO5            5'h00
`define CPF_ZERO4            4'h0
`define CPF_ZERO3            3'h0
`define CPF_ZERO2            2'h0
`define CPF_ZERO16           16'h0000

`endif

/* logic/cpf_agen.v */
`timescale 1ns/1ps
`include "cpf_regs.vh"

module cpf_agen
(
    // Operands
    input  wire [31:0] base,
    input  wire [31:0] index,
    input  wire [7:0]  imm8,
    input  wire [1:0]  shift,
    input  wire        indexed,
    // Result
    output wire [31:0] addr
);

    wire [31:0] offs_raw;
    wire [31:0] offs;

    // Zero-extended offset, then scaled by 1, 2, 4 or 8
    assign offs_raw = indexed ? index : {24'h00_0000, imm8};
    assign offs     = offs_raw << shift;
    assign addr     = base + offs;

endmodule

/* logic/cpf_core.v */
`timescale 1ns/1ps
`include "cpf_regs.vh"

module cpf_core
#(
    parameter NUM_CP   = 8,
    parameter FP_CP    = 0,
    parameter PRECISE  = 1,
    parameter SPECULATE = 1
)
(
    // Clock and reset
    input  wire        clk,
    input  wire        nrst,
    // Special register access
    input  wire        sr_valid,
    input  wire [1:0]  sr_op,
    input  wire [7:0]  sr_num,
    input  wire [31:0] sr_wdata,
    output reg  [31:0] sr_rdata_r,
    output reg         sr_done_r,
    output reg         sr_bad_r,
    // User state access
    input  wire        ur_valid,
    input  wire        ur_write,
    input  wire [7:0]  ur_num,
    input  wire [31:0] ur_wdata,
    output reg  [31:0] ur_rdata_r,
    output reg         ur_done_r,
    output reg         ur_busy_r,
    output reg         ur_bad_r,
    // Generic coprocessor state reference
    input  wire        chk_valid,
    input  wire [2:0]  chk_cp,
    input  wire        chk_bool_only,
    output reg         cp_dis_exc_r,
    output reg  [2:0]  cp_dis_num_r,
    // Floating-point operation issue
    input  wire        op_valid,
    input  wire [3:0]  op_dest,
    input  wire [31:0] op_result,
    input  wire [31:0] op_default,
    input  wire [4:0]  op_raise,
    output reg  [1:0]  rnd_mode_r,
    output reg  [3:0]  rnd_onehot_r,
    output reg         fp_exc_r,
    output reg         op_done_r,
    // Coprocessor load/store
    input  wire        ls_valid,
    input  wire [3:0]  ls_opcode,
    input  wire        ls_load,
    input  wire        ls_update,
    input  wire [1:0]  ls_shift,
    input  wire [3:0]  ls_reg,
    input  wire [31:0] ls_base,
    input  wire [31:0] ls_index,
    input  wire [7:0]  ls_imm8,
    input  wire [31:0] ls_load_data,
    output reg  [31:0] ls_addr_r,
    output reg  [31:0] ls_store_data_r,
    output reg         ls_go_r,
    output reg         ls_base_wb_r,
    // Register file read and speculation
    input  wire [3:0]  fr_rd_idx,
    input  wire        fv_clear,
    output reg  [31:0] fr_rd_data_r,
    output reg  [15:0] fp_valid_bits_r
);

    localparam ST_IDLE = 2'b01;
    localparam ST_BUSY = 2'b10;

    reg [NUM_CP-1:0] coprocessor_enable_mask;
    reg [31:0]       fp_register_file [0:15];
    reg [31:0]       fp_control_word;
    reg [31:0]       fp_status_word;
    reg [1:0]        state_r;
    reg [1:0]        state_nxt;
    reg              pend_r;
    reg [3:0]        pend_dest_r;
    reg [31:0]       pend_res_r;
    reg [31:0]       pend_dflt_r;
    reg [4:0]        pend_raise_r;
    reg [4:0]        pend_ena_r;
    reg              pend_rsv_r;
    reg              defer_r;
    reg              ur_hold_r;
    reg              ur_wr_hold_r;
    reg [7:0]        ur_num_hold_r;
    reg [31:0]       ur_wd_hold_r;
    reg [31:0]       fc_nxt;
    reg [31:0]       fs_nxt;
    reg [4:0]        flag_set;
    reg              fr_we;
    reg [3:0]        fr_widx;
    reg [31:0]       fr_wdat;

    wire [31:0] agen_addr;
    wire        ls_op_ok;
    wire        ls_dis;
    wire        op_dis;
    wire        chk_dis;
    wire        ur_dis;
    wire        ur_go;
    wire        ur_is_ctl;
    wire        ur_is_sts;
    wire        op_go;
    wire        rsv_nz;
    wire [4:0]  pend_hit;
    wire        pend_abort;

    // One bit per coprocessor, clear means disabled
    function cp_off;
        input [NUM_CP-1:0] mask;
        input [2:0]        num;
        begin
            cp_off = ~mask[num];
        end
    endfunction

    function [3:0] rnd_decode;
        input [1:0] rf;
        begin
            case (rf)
                `CPF_RND_NEAREST:  rnd_decode = 4'b0001;
                `CPF_RND_ZERO:     rnd_decode = 4'b0010;
                `CPF_RND_PLUS_INF: rnd_decode = 4'b0100;
                default:           rnd_decode = 4'b1000;
            endcase
        end
    endfunction

    cpf_agen u_agen
    (
        .base    (ls_base),
        .index   (ls_index),
        .imm8    (ls_imm8),
        .shift   (ls_shift),
        .indexed (ls_opcode == `CPF_OP_LDST_INDEXED),
        .addr    (agen_addr)
    );

    // Only the two reserved opcodes reach the coprocessor
    assign ls_op_ok = ls_valid && ((ls_opcode == `CPF_OP_LDST_IMM) ||
                                   (ls_opcode == `CPF_OP_LDST_INDEXED));
    assign ls_dis   = ls_op_ok && cp_off(coprocessor_enable_mask, FP_CP[2:0]);
    assign op_dis   = op_valid && cp_off(coprocessor_enable_mask, FP_CP[2:0]);
    assign chk_dis  = chk_valid && !chk_bool_only &&
                      cp_off(coprocessor_enable_mask, chk_cp);
    assign ur_is_ctl = ur_num_hold_r == `CPF_UR_FP_CONTROL;
    assign ur_is_sts = ur_num_hold_r == `CPF_UR_FP_STATUS;
    assign ur_dis   = ur_hold_r && (ur_is_ctl || ur_is_sts) &&
                      cp_off(coprocessor_enable_mask, FP_CP[2:0]);
    // Status read waits until pending work has landed
    assign ur_go    = ur_hold_r && !(ur_is_sts && !ur_wr_hold_r && pend_r);
    assign op_go    = op_valid && !op_dis;
    assign rsv_nz   = (fp_control_word[`CPF_FC_RSV_MSB:`CPF_FC_RSV_LSB] != 20'h0_0000) ||
                      (fp_status_word[`CPF_FS_RSV_MSB:`CPF_FS_RSV_LSB] != 20'h0_0000);
    assign pend_hit   = pend_raise_r & pend_ena_r;
    assign pend_abort = pend_rsv_r || ((pend_hit != `CPF_ZERO5) && (PRECISE != 0));

    // Completion: flags, result write and control/status updates
    always @*
    begin
        state_nxt = state_r;
        flag_set  = `CPF_ZERO5;
        fr_we     = 1'b0;
        fr_widx   = ls_reg;
        fr_wdat   = ls_load_data;
        fc_nxt    = fp_control_word;
        fs_nxt    = fp_status_word;
        case (state_r)
            ST_IDLE:
            begin
                if (op_go)
                    state_nxt = ST_BUSY;
            end
            ST_BUSY:
            begin
                if (!op_go)
                    state_nxt = ST_IDLE;
                if (!pend_abort)
                begin
                    // Disabled raises set flags; imprecise mode sets all
                    flag_set = (PRECISE != 0) ? (pend_raise_r & ~pend_ena_r)
                                              : pend_raise_r;
                    fr_we    = 1'b1;
                    fr_widx  = pend_dest_r;
                    fr_wdat  = (pend_raise_r != `CPF_ZERO5) ? pend_dflt_r
                                                             : pend_res_r;
                end
            end
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (!fr_we && ls_op_ok && !ls_dis && ls_load)
            fr_we = 1'b1;
        if (ur_go && !ur_dis && ur_wr_hold_r && ur_is_ctl)
            fc_nxt = ur_wd_hold_r & `CPF_FC_WR_MASK;
        if (ur_go && !ur_dis && ur_wr_hold_r && ur_is_sts)
            fs_nxt = ur_wd_hold_r & `CPF_FS_WR_MASK;
        // A flag raised in the write cycle survives it
        fs_nxt[`CPF_FS_FLG_MSB:`CPF_FS_FLG_LSB] =
            fs_nxt[`CPF_FS_FLG_MSB:`CPF_FS_FLG_LSB] | flag_set;
    end

    // Enable mask: deliberately without reset
    always @(posedge clk)
    begin
        if (sr_valid && (sr_num == `CPF_SR_CP_ENABLE) &&
            (sr_op != `CPF_SR_OP_READ))
            coprocessor_enable_mask <= sr_wdata[NUM_CP-1:0];
    end

    // Register file storage, no reset
    always @(posedge clk)
    begin
        if (fr_we)
            fp_register_file[fr_widx] <= fr_wdat;
    end

    always @(posedge clk)
    begin
        if (!nrst)
        begin
            state_r         <= ST_IDLE;
            pend_r          <= 1'b0;
            pend_dest_r     <= `CPF_ZERO4;
            pend_res_r      <= `CPF_ZERO32;
            pend_dflt_r     <= `CPF_ZERO32;
            pend_raise_r    <= `CPF_ZERO5;
            pend_ena_r      <= `CPF_ZERO5;
            pend_rsv_r      <= 1'b0;
            defer_r         <= 1'b0;
            fp_control_word <= `CPF_ZERO32;
            fp_status_word  <= `CPF_ZERO32;
            ur_hold_r       <= 1'b0;
            ur_wr_hold_r    <= 1'b0;
            ur_num_hold_r   <= 8'h00;
            ur_wd_hold_r    <= `CPF_ZERO32;
            sr_rdata_r      <= `CPF_ZERO32;
            sr_done_r       <= 1'b0;
            sr_bad_r        <= 1'b0;
            ur_rdata_r      <= `CPF_ZERO32;
            ur_done_r       <= 1'b0;
            ur_busy_r       <= 1'b0;
            ur_bad_r        <= 1'b0;
            cp_dis_exc_r    <= 1'b0;
            cp_dis_num_r    <= `CPF_ZERO3;
            rnd_mode_r      <= `CPF_ZERO2;
            rnd_onehot_r    <= 4'b0001;
            fp_exc_r        <= 1'b0;
            op_done_r       <= 1'b0;
            ls_addr_r       <= `CPF_ZERO32;
            ls_store_data_r <= `CPF_ZERO32;
            ls_go_r         <= 1'b0;
            ls_base_wb_r    <= 1'b0;
            fr_rd_data_r    <= `CPF_ZERO32;
            fp_valid_bits_r <= `CPF_ZERO16;
        end
        else
        begin
            state_r        <= state_nxt;
            fp_control_word <= fc_nxt;
            fp_status_word  <= fs_nxt;

            // Special register port
            sr_done_r <= sr_valid;
            sr_bad_r  <= sr_valid && (sr_num != `CPF_SR_CP_ENABLE);
            if (sr_valid && (sr_num == `CPF_SR_CP_ENABLE) &&
                (sr_op != `CPF_SR_OP_WRITE))
                sr_rdata_r <= {{(32-NUM_CP){1'b0}}, coprocessor_enable_mask};

            // Issue stage latches control at issue time
            pend_r <= op_go;
            if (op_go)
            begin
                pend_dest_r  <= op_dest;
                pend_res_r   <= op_result;
                pend_dflt_r  <= op_default;
                pend_raise_r <= op_raise;
                pend_ena_r   <= fp_control_word[`CPF_FC_ENA_MSB:`CPF_FC_ENA_LSB];
                pend_rsv_r   <= rsv_nz || ((PRECISE == 0) && defer_r);
                rnd_mode_r   <= fp_control_word[`CPF_FC_RND_MSB:`CPF_FC_RND_LSB];
                rnd_onehot_r <= rnd_decode(fp_control_word[`CPF_FC_RND_MSB:`CPF_FC_RND_LSB]);
            end
            op_done_r <= pend_r;
            fp_exc_r  <= pend_r && pend_abort;
            // Imprecise: remember enabled hit, trap the next op
            if (pend_r && (PRECISE == 0))
                defer_r <= (pend_hit != `CPF_ZERO5) && !pend_rsv_r;

            // Disabled coprocessor exceptions, before any update
            cp_dis_exc_r <= chk_dis || op_dis || ls_dis || ur_dis;
            if (chk_dis)
                cp_dis_num_r <= chk_cp;
            else if (op_dis || ls_dis || ur_dis)
                cp_dis_num_r <= FP_CP[2:0];

            // User state access, held while stalled
            if (ur_valid && !ur_hold_r)
            begin
                ur_hold_r     <= 1'b1;
                ur_wr_hold_r  <= ur_write;
                ur_num_hold_r <= ur_num;
                ur_wd_hold_r  <= ur_wdata;
            end
            else if (ur_go)
                ur_hold_r <= 1'b0;
            ur_busy_r <= (ur_valid && !ur_hold_r) || (ur_hold_r && !ur_go);
            ur_done_r <= ur_go;
            ur_bad_r  <= ur_go && !ur_is_ctl && !ur_is_sts;
            if (ur_go && !ur_wr_hold_r && !ur_dis)
            begin
                if (ur_is_ctl)
                    ur_rdata_r <= fp_control_word;
                else if (ur_is_sts)
                    ur_rdata_r <= fp_status_word;
                else
                    ur_rdata_r <= `CPF_ZERO32;
            end

            // Load/store address and base update
            ls_go_r      <= ls_op_ok && !ls_dis;
            ls_base_wb_r <= ls_op_ok && !ls_dis && ls_update;
            if (ls_op_ok && !ls_dis)
            begin
                ls_addr_r       <= agen_addr;
                ls_store_data_r <= fp_register_file[ls_reg];
            end

            fr_rd_data_r <= fp_register_file[fr_rd_idx];
            if (SPECULATE != 0)
            begin
                if (fv_clear)
                    fp_valid_bits_r <= `CPF_ZERO16;
                else if (fr_we)
                    fp_valid_bits_r[fr_widx] <= 1'b1;
            end
        end
    end

endmodule

/* verif/cpf_core_checker.sv */
`timescale 1ns/1ps
`include "cpf_regs.vh"
module cpf_core_checker
(
    // Clock and reset
    input wire        clk,
    input wire        nrst,
    // Requests
    input wire        sr_valid,
    input wire [7:0]  sr_num,
    input wire        ur_valid,
    input wire        chk_valid,
    input wire        chk_bool_only,
    input wire        op_valid,
    input wire        ls_valid,
    input wire [3:0]  ls_opcode,
    input wire        ls_update,
    input wire [1:0]  ls_shift,
    input wire [31:0] ls_base,
    input wire [31:0] ls_index,
    input wire [7:0]  ls_imm8,
    // Answers
    input wire        sr_done_r,
    input wire        sr_bad_r,
    input wire        ur_busy_r,
    input wire        ur_done_r,
    input wire        cp_dis_exc_r,
    input wire        op_done_r,
    input wire        fp_exc_r,
    input wire [1:0]  rnd_mode_r,
    input wire [3:0]  rnd_onehot_r,
    input wire        ls_go_r,
    input wire [31:0] ls_addr_r,
    input wire        ls_base_wb_r
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    logic [31:0] exp_addr_r;

    always @(posedge clk)
    begin
        exp_addr_r <= ls_base + ((ls_opcode == 4'h4 ? ls_index : {24'h00_0000, ls_imm8}) << ls_shift);
    end

    a_sr_good_num: assert property (sr_valid && sr_num == `CPF_SR_CP_ENABLE |=> sr_done_r && !sr_bad_r)
        else $error("mask access not answered");
    a_sr_bad_num: assert property (sr_valid && sr_num != `CPF_SR_CP_ENABLE |=> sr_bad_r)
        else $error("bad special number not refused");
    a_bool_exempt: assert property (chk_valid && chk_bool_only && !op_valid && !ur_valid && !ls_valid
        && !ur_busy_r |=> !cp_dis_exc_r) else $error("boolean reference trapped");
    a_op_answer: assert property (op_valid ##1 !cp_dis_exc_r |=> op_done_r)
        else $error("fp op not completed");
    a_exc_with_done: assert property (fp_exc_r |-> op_done_r)
        else $error("fp exception without completion");
    a_rnd_decode: assert property (rnd_onehot_r == (4'h1 << rnd_mode_r))
        else $error("rounding decode wrong");
    a_ur_bounded: assert property ($rose(ur_busy_r) |-> ##[1:4] ur_done_r)
        else $error("user access stalled too long");
    a_ls_taken: assert property (ls_valid && (ls_opcode == 4'h3 || ls_opcode == 4'h4) ##1 !cp_dis_exc_r
        |-> ls_go_r) else $error("load/store not started");
    a_ls_other: assert property (ls_valid && ls_opcode != 4'h3 && ls_opcode != 4'h4 |=> !ls_go_r)
        else $error("foreign opcode started load/store");
    a_ls_addr: assert property (ls_go_r |-> ls_addr_r == exp_addr_r)
        else $error("load/store address wrong");
    a_ls_update: assert property (ls_go_r |-> ls_base_wb_r == $past(ls_update))
        else $error("base write-back wrong");
endmodule

bind cpf_core cpf_core_checker chk_u
(
    .clk, .nrst, .sr_valid, .sr_num, .ur_valid, .chk_valid, .chk_bool_only, .op_valid, .ls_valid,
    .ls_opcode, .ls_update, .ls_shift, .ls_base, .ls_index, .ls_imm8, .sr_done_r, .sr_bad_r,
    .ur_busy_r, .ur_done_r, .cp_dis_exc_r, .op_done_r, .fp_exc_r, .rnd_mode_r, .rnd_onehot_r,
    .ls_go_r, .ls_addr_r, .ls_base_wb_r
);

/* verif/cpf_pipe_model.sv */
`timescale 1ns/1ps
module cpf_pipe_model
#(
    parameter BASE0 = 32'h0000_1000
)
(
    // Clock and reset
    input  wire        clk,
    input  wire        nrst,
    // Base write-back
    input  wire        ls_base_wb_r,
    input  wire [31:0] ls_addr_r,
    // Base address register
    output reg  [31:0] base_r
);
    always @(posedge clk)
    begin
        if (!nrst)
            base_r <= BASE0;
        else if (ls_base_wb_r)
            base_r <= ls_addr_r;
    end
endmodule

/* verif/cpf_core_tb_top.sv */
`timescale 1ns/1ps
`include "cpf_regs.vh"
module cpf_core_tb_top;
    logic        clk, nrst, sr_valid, ur_valid, ur_write, chk_valid, chk_bool_only, op_valid;
    logic        ls_valid, ls_load, ls_update, fv_clear;
    logic [1:0]  sr_op, ls_shift;
    logic [2:0]  chk_cp;
    logic [3:0]  op_dest, ls_opcode, fr_rd_idx, ls_reg;
    logic [4:0]  op_raise;
    logic [7:0]  sr_num, ur_num, ls_imm8;
    logic [31:0] sr_wdata, ur_wdata, op_result, op_default, ls_index, ls_load_data;
    wire  [31:0] sr_rdata_r, ur_rdata_r, ls_addr_r, ls_store_data_r, fr_rd_data_r, base_r;
    wire         sr_done_r, sr_bad_r, ur_done_r, ur_busy_r, ur_bad_r, cp_dis_exc_r, fp_exc_r;
    wire         op_done_r, ls_go_r, ls_base_wb_r;
    wire  [2:0]  cp_dis_num_r;
    wire  [1:0]  rnd_mode_r;
    wire  [3:0]  rnd_onehot_r;
    wire  [15:0] fp_valid_bits_r;
    integer      err_total, check_count, i;

    cpf_core dut_u
    (
        .clk, .nrst, .sr_valid, .sr_op, .sr_num, .sr_wdata, .sr_rdata_r, .sr_done_r, .sr_bad_r,
        .ur_valid, .ur_write, .ur_num, .ur_wdata, .ur_rdata_r, .ur_done_r, .ur_busy_r, .ur_bad_r,
        .chk_valid, .chk_cp, .chk_bool_only, .cp_dis_exc_r, .cp_dis_num_r, .op_valid, .op_dest,
        .op_result, .op_default, .op_raise, .rnd_mode_r, .rnd_onehot_r, .fp_exc_r, .op_done_r,
        .ls_valid, .ls_opcode, .ls_load, .ls_update, .ls_shift, .ls_reg, .ls_base(base_r),
        .ls_index, .ls_imm8, .ls_load_data, .ls_addr_r, .ls_store_data_r, .ls_go_r, .ls_base_wb_r,
        .fr_rd_idx, .fv_clear, .fr_rd_data_r, .fp_valid_bits_r
    );

    cpf_pipe_model model_u (.clk, .nrst, .ls_base_wb_r, .ls_addr_r, .base_r);

    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp)
            begin
                err_total = err_total + 1;
                $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask

    task complete_run;
        begin
            $display("checks %0d mismatches %0d", check_count, err_total);
            if (err_total == 0 && check_count > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask

    task sr_acc(input [1:0] op, input [7:0] num, input [31:0] wd);
        begin
            // Idle edge between requests, strobe never toggles in one step
            @(negedge clk);
            {sr_valid, sr_op, sr_num, sr_wdata} = {1'b1, op, num, wd};
            @(negedge clk);
            sr_valid = 0;
        end
    endtask

    task ur_acc(input w, input [7:0] num, input [31:0] wd);
        integer n;
        begin
            {ur_valid, ur_write, ur_num, ur_wdata} = {1'b1, w, num, wd};
            @(negedge clk);
            ur_valid = 0;
            op_valid = 0;
            n = 0;
            while (ur_done_r !== 1'b1 && n < 20)
            begin
                @(negedge clk);
                n = n + 1;
            end
            if (n == 20)
            begin
                check("ur_wait", 0, 1);
                complete_run;
            end
        end
    endtask

    task fp_op(input [3:0] d, input [31:0] res, input [31:0] dflt, input [4:0] r);
        begin
            {op_valid, op_dest, op_result, op_default, op_raise} = {1'b1, d, res, dflt, r};
            @(negedge clk);
            op_valid = 0;
            @(negedge clk);
            check("op_done", op_done_r, 1);
        end
    endtask

    task ls_acc(input [3:0] opc, input ld, input up, input [1:0] sh, input [31:0] ix, input [7:0] im,
                input [31:0] dat);
        begin
            @(negedge clk);
            {ls_valid, ls_opcode, ls_load, ls_update, ls_shift, ls_index, ls_imm8, ls_load_data} =
                {1'b1, opc, ld, up, sh, ix, im, dat};
            @(negedge clk);
            ls_valid = 0;
        end
    endtask

    task fr_chk(input [3:0] ix, input [31:0] ex);
        begin
            fr_rd_idx = ix;
            @(negedge clk);
            check("fr", fr_rd_data_r, ex);
        end
    endtask

    initial
    begin
        clk = 0;
        forever #4 clk = ~clk;
    end

    initial
    begin
        {nrst, sr_valid, ur_valid, ur_write, chk_valid, chk_bool_only, op_valid, ls_valid} = 0;
        {ls_load, ls_update, fv_clear, sr_op, ls_shift, chk_cp, op_dest, ls_opcode, fr_rd_idx} = 0;
        {op_raise, sr_num, ur_num, ls_imm8, sr_wdata, ur_wdata, op_result, op_default} = 0;
        {ls_index, ls_load_data} = 0;
        ls_reg = 4'h5;
        err_total = 0;
        check_count = 0;
        repeat (8) @(negedge clk);
        nrst = 1;
        check("onehot", rnd_onehot_r, 1);
        sr_acc(`CPF_SR_OP_WRITE, `CPF_SR_CP_ENABLE, 0);
        sr_acc(`CPF_SR_OP_EXCHANGE, `CPF_SR_CP_ENABLE, 32'h0000_005a);
        check("sr_old", sr_rdata_r, 0);
        sr_acc(`CPF_SR_OP_READ, `CPF_SR_CP_ENABLE, 0);
        check("sr_rd", sr_rdata_r, 32'h0000_005a);
        sr_acc(`CPF_SR_OP_READ, 8'he1, 0);
        check("sr_bad", sr_bad_r, 1);
        for (i = 0; i < 9; i = i + 1)
        begin
            {chk_valid, chk_cp, chk_bool_only} = {1'b1, i[2:0], i == 8};
            @(negedge clk);
            check("cp_dis", cp_dis_exc_r, (32'h0000_00a5 >> i) & 1);
            if (cp_dis_exc_r === 1'b1)
                check("cp_num", cp_dis_num_r, i);
        end
        chk_valid = 0;
        sr_acc(`CPF_SR_OP_WRITE, `CPF_SR_CP_ENABLE, 32'h0000_00ff);
        @(negedge clk);
        ur_acc(1, `CPF_UR_FP_CONTROL, 32'hffff_ffff);
        ur_acc(0, `CPF_UR_FP_CONTROL, 0);
        check("ctl", ur_rdata_r, 32'hffff_f07f);
        ur_acc(1, `CPF_UR_FP_STATUS, 32'hffff_ffff);
        ur_acc(0, `CPF_UR_FP_STATUS, 0);
        check("sts", ur_rdata_r, 32'hffff_ff80);
        ur_acc(1, 8'hea, 0);
        check("ur_bad", ur_bad_r, 1);
        fp_op(1, 0, 0, 0);
        check("rsv_ctl", fp_exc_r, 1);
        ur_acc(1, `CPF_UR_FP_CONTROL, 0);
        fp_op(1, 0, 0, 0);
        check("rsv_sts", fp_exc_r, 1);
        ur_acc(1, `CPF_UR_FP_STATUS, 0);
        fp_op(2, 32'h3f80_0000, 32'h7fc0_0000, 0);
        fr_chk(2, 32'h3f80_0000);
        fp_op(3, 32'h3f80_0000, 32'h7fc0_0000, 5'h10);
        fr_chk(3, 32'h7fc0_0000);
        ur_acc(0, `CPF_UR_FP_STATUS, 0);
        check("flag", ur_rdata_r, 32'h0000_0800);
        for (i = 0; i < 5; i = i + 1)
        begin
            ur_acc(1, `CPF_UR_FP_STATUS, 0);
            ur_acc(1, `CPF_UR_FP_CONTROL, 32'h0000_0004 << i);
            fp_op(3, 0, 0, 5'h01 << i);
            check("en_exc", fp_exc_r, 1);
            fp_op(4, 0, 0, 5'h01 << (i + 1) % 5);
            check("dis_exc", fp_exc_r, 0);
            ur_acc(0, `CPF_UR_FP_STATUS, 0);
            check("flags", ur_rdata_r, 32'h0000_0080 << (i + 1) % 5);
        end
        fr_chk(3, 32'h7fc0_0000);
        for (i = 0; i < 4; i = i + 1)
        begin
            ur_acc(1, `CPF_UR_FP_STATUS, 0);
            ur_acc(1, `CPF_UR_FP_CONTROL, i);
            {op_valid, op_dest, op_raise} = {1'b1, 4'h6, 5'h01};
            ur_acc(0, `CPF_UR_FP_STATUS, 0);
            check("stall", ur_rdata_r, 32'h0000_0080);
            check("rnd", rnd_mode_r, i);
            check("rnd1h", rnd_onehot_r, 1 << i);
        end
        check("fv", fp_valid_bits_r[2], 1);
        fv_clear = 1;
        @(negedge clk);
        fv_clear = 0;
        check("fv_clr", fp_valid_bits_r, 0);
        ls_acc(`CPF_OP_LDST_IMM, 1, 1, 2, 0, 8'h10, 32'hcafe_0001);
        check("ls_addr", ls_addr_r, 32'h0000_1040);
        check("ls_wb", ls_base_wb_r, 1);
        fr_chk(5, 32'hcafe_0001);
        ls_acc(`CPF_OP_LDST_INDEXED, 0, 0, 3, 3, 0, 0);
        check("ls_addr", ls_addr_r, 32'h0000_1058);
        check("ls_st", ls_store_data_r, 32'hcafe_0001);
        ls_acc(4'h5, 0, 0, 0, 0, 0, 0);
        check("ls_go", ls_go_r, 0);
        sr_acc(`CPF_SR_OP_WRITE, `CPF_SR_CP_ENABLE, 32'h0000_00fe);
        @(negedge clk);
        {op_valid, op_dest, op_raise} = {1'b1, 4'h7, 5'h00};
        @(negedge clk);
        op_valid = 0;
        check("op_dis", cp_dis_exc_r, 1);
        @(negedge clk);
        check("op_none", op_done_r, 0);
        check("fv_none", fp_valid_bits_r[7], 0);
        ls_reg = 4'h8;
        ls_acc(`CPF_OP_LDST_IMM, 1, 1, 0, 0, 8'h04, 32'h1234_5678);
        check("ls_dis", cp_dis_exc_r, 1);
        check("ls_none", ls_go_r, 0);
        check("fv_ls", fp_valid_bits_r[8], 0);
        ur_acc(0, `CPF_UR_FP_CONTROL, 0);
        check("ur_dis", cp_dis_exc_r, 1);
        complete_run;
    end
endmodule
